// File: fsw_core_model.sv
// core model: ends an instruction slot every 2 cycles, every 3 when slow
// assumes the sequencer's stall flag halts the core entirely
`timescale 1ns/1ns
module fsw_core_model (
    input wire clk,
    input wire rst,
    input wire slow,
    input wire core_stall_reg,
    output reg slot_done
);
    reg [1:0] cnt_reg = 2'h0;
    initial slot_done = 1'h0;
    // no interrupts are taken, so a key sequence is never split
    always @(negedge clk) begin
        if (rst || core_stall_reg) begin
            slot_done <= 1'h0;
        end else begin
            cnt_reg <= (cnt_reg >= {1'h0, slow} + 2'h1) ? 2'h0 : cnt_reg + 2'h1;
            slot_done <= (cnt_reg == 2'h0);
        end
    end
endmodule

// File: fsw_defines.vh
// constants for the flash self-write sequencer
// assumes a 25 MHz instruction clock and a 14-bit program word
`ifndef FSW_DEFINES_VH
`define FSW_DEFINES_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define FSW_CLK_MHZ 25
`define FSW_PROG_TIME_US 2000
`define FSW_PROG_CYCLES (`FSW_PROG_TIME_US * `FSW_CLK_MHZ)
`define FSW_FORCED_SLOTS 2'h2

// ----------------------------------------------------------------
// memory shape
// ----------------------------------------------------------------
`define FSW_WORD_W 14
`define FSW_ADDR_W 12
`define FSW_ROW_W 5
`define FSW_UID_W 2
`define FSW_ERASED_WORD 14'h3fff

// ----------------------------------------------------------------
// unlock keys
// ----------------------------------------------------------------
`define FSW_KEY_FIRST 8'h55
`define FSW_KEY_SECOND 8'haa

// ----------------------------------------------------------------
// operation select codes
// ----------------------------------------------------------------
`define FSW_OP_ERASE 2'h0
`define FSW_OP_LOAD 2'h1
`define FSW_OP_PROG 2'h2
`define FSW_OP_UID 2'h3

`endif

// File: fsw_flash_array.v
// program flash array, row write latches and user id words
// driven only by the sequencer; one operation per strobe
`timescale 1ns/1ns
`include "fsw_defines.vh"

module fsw_flash_array (
    input wire clk,
    input wire rst,
    input wire [`FSW_ADDR_W-1:0] addr,
    input wire cfg_space,
    input wire [`FSW_WORD_W-1:0] wdata,
    input wire latch_we,
    input wire erase_row,
    input wire prog_row,
    input wire prog_uid,
    output reg [`FSW_WORD_W-1:0] rdata
);
    localparam ROW_LEN = 1 << `FSW_ROW_W;
    localparam UIDS = 1 << `FSW_UID_W;

    reg [`FSW_WORD_W-1:0] mem [0:(1 << `FSW_ADDR_W)-1];
    reg [`FSW_WORD_W-1:0] latch [0:ROW_LEN-1];
    reg [`FSW_WORD_W-1:0] uid [0:UIDS-1];
    wire [`FSW_ADDR_W-`FSW_ROW_W-1:0] row;
    wire [`FSW_ROW_W-1:0] col;
    integer i;

    assign row = addr[`FSW_ADDR_W-1:`FSW_ROW_W];
    assign col = addr[`FSW_ROW_W-1:0];

    // ------------------------------------------------------------
    // array updates; contents survive reset like real flash
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (latch_we) begin
            latch[col] <= wdata;
        end
        if (erase_row) begin
            for (i = 0; i < ROW_LEN; i = i + 1) begin
                mem[{row, i[`FSW_ROW_W-1:0]}] <= `FSW_ERASED_WORD;
            end
        end
        if (prog_row) begin
            for (i = 0; i < ROW_LEN; i = i + 1) begin
                mem[{row, i[`FSW_ROW_W-1:0]}] <= latch[i];
            end
        end
        if (prog_uid) begin
            for (i = 0; i < UIDS; i = i + 1) begin
                uid[i] <= latch[i];
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rdata <= {`FSW_WORD_W{1'b0}};
        end else if (cfg_space) begin
            rdata <= uid[addr[`FSW_UID_W-1:0]];
        end else begin
            rdata <= mem[addr];
        end
    end
endmodule

// File: fsw_seq_checker.sv
// checker for the self-write sequencer, sees only its top ports
// assumes slot_done pulses come from a core model that halts on stall
`timescale 1ns/1ns
`include "fsw_defines.vh"
module fsw_seq_checker #(
    parameter PROG_CYCLES = 50000
) (
    input wire clk,
    input wire rst,
    input wire read_request,
    input wire write_request,
    input wire slot_done,
    input wire [1:0] op_select,
    input wire no_operation_slot_reg,
    input wire core_stall_reg,
    input wire read_busy_reg,
    input wire write_busy_reg,
    input wire unlock_fail_reg
);
    reg [1:0] nop_slots_reg = 2'h0;
    reg [31:0] stall_cnt_reg = 32'h0;
    reg [1:0] op_reg = 2'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // counters stand in for repetitions far longer than 8 cycles
    always @(posedge clk) begin
        nop_slots_reg <= (rst || !no_operation_slot_reg) ? 2'h0
            : nop_slots_reg + {1'h0, slot_done};
        stall_cnt_reg <= (rst || !core_stall_reg) ? 32'h0 : stall_cnt_reg + 32'h1;
        if (write_request && !write_busy_reg)
            op_reg <= op_select;
    end
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    sequence s_write_taken;
        write_request && !write_busy_reg && !read_busy_reg && !core_stall_reg;
    endsequence
    sequence s_nop_over;
        $fell(no_operation_slot_reg);
    endsequence
    a_taken_answer: assert property (s_write_taken |=> write_busy_reg != unlock_fail_reg)
        else $error("write request neither started nor refused");
    a_busy_nop: assert property ($rose(write_busy_reg) |-> no_operation_slot_reg)
        else $error("write started without forced slots");
    a_nop_two_slots: assert property (s_nop_over |->
        nop_slots_reg == 2'h2 && $past(slot_done))
        else $error("forced slots not ended by the second slot end");
    a_nop_no_stall: assert property (no_operation_slot_reg |-> !core_stall_reg)
        else $error("stall during forced slots");
    a_stall_length: assert property ($fell(core_stall_reg) |-> stall_cnt_reg == PROG_CYCLES)
        else $error("stall length wrong");
    a_stall_after_nop: assert property (s_nop_over |->
        core_stall_reg == (op_reg != `FSW_OP_LOAD))
        else $error("stall after forced slots wrong for operation");
    a_fail_quiet: assert property (unlock_fail_reg |-> !write_busy_reg && !core_stall_reg)
        else $error("refused request still started");
    a_read_busy: assert property (read_request && !read_busy_reg && !write_busy_reg
        |=> read_busy_reg)
        else $error("read request not taken");
endmodule
bind fsw_sequencer fsw_seq_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (.clk, .rst,
    .read_request, .write_request, .slot_done, .op_select, .no_operation_slot_reg,
    .core_stall_reg, .read_busy_reg, .write_busy_reg, .unlock_fail_reg);

// File: fsw_sequencer.v
// flash self-write sequencer: word read, unlock check, forced slots, stall
// core strobes are one-cycle pulses on clk; slot_done ends each instruction
`timescale 1ns/1ns
`include "fsw_defines.vh"

// Contract
// - two slots ignored, then read data presented (here read data is captured in S_RD_LOAD, before the two slots)
// - protected operations only after unbroken unlock
// - write request forces next two no-op slots
// - erase or program stalls core about 2ms
// - latch load never stalls, only two slots
module fsw_sequencer #(
    parameter PROG_CYCLES = `FSW_PROG_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire [7:0] core_wdata,
    input wire addr_low_we,
    input wire addr_high_we,
    input wire key_we,
    input wire [`FSW_WORD_W-1:0] write_word,
    input wire config_space_select,
    input wire [1:0] op_select,
    input wire read_request,
    input wire write_request,
    input wire slot_done,
    output reg [7:0] word_address_low_reg,
    output reg [7:0] word_address_high_reg,
    output reg [7:0] read_data_low_reg,
    output reg [5:0] read_data_high_reg,
    output reg no_operation_slot_reg,
    output reg core_stall_reg,
    output reg read_busy_reg,
    output reg write_busy_reg,
    output reg unlock_fail_reg
);
    localparam S_IDLE = 3'h0;
    localparam S_RD_SLOTS = 3'h1;
    localparam S_WR_SLOTS = 3'h2;
    localparam S_STALL = 3'h3;
    localparam S_RD_LOAD = 3'h4;

    localparam K_NONE = 2'h0;
    localparam K_FIRST = 2'h1;
    localparam K_SECOND = 2'h2;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [1:0] key_reg;
    reg [1:0] key_next;
    reg strobe_seen_reg;
    reg [1:0] slot_cnt_reg;
    reg [1:0] slot_cnt_next;
    reg [15:0] stall_cnt_reg;
    reg [15:0] stall_cnt_next;
    reg [1:0] op_reg;
    reg cfg_reg;
    reg [`FSW_WORD_W-1:0] wword_reg;
    reg go_latch;
    reg go_erase;
    reg go_prog;
    reg go_uid;
    reg capture;
    wire [`FSW_WORD_W-1:0] flash_rdata;
    wire [`FSW_ADDR_W-1:0] flash_addr;
    wire any_strobe;
    wire unlocked;

    // op that needs the long stall
    function stalls;
        input [1:0] op;
        begin
            stalls = (op != `FSW_OP_LOAD);
        end
    endfunction

    assign flash_addr = {word_address_high_reg[`FSW_ADDR_W-9:0], word_address_low_reg};
    assign any_strobe = addr_low_we | addr_high_we | key_we | read_request | write_request;
    assign unlocked = (key_reg == K_SECOND);

    // ------------------------------------------------------------
    // address registers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            word_address_low_reg <= 8'h00;
            word_address_high_reg <= 8'h00;
        end else begin
            if (addr_low_we) begin
                word_address_low_reg <= core_wdata;
            end
            if (addr_high_we) begin
                word_address_high_reg <= core_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // unlock key tracker
    // ------------------------------------------------------------
    // any other write, a wrong key, or a slot without a step breaks it
    always @* begin
        key_next = key_reg;
        if (key_we) begin
            if (core_wdata == `FSW_KEY_FIRST && key_reg == K_NONE) begin
                key_next = K_FIRST;
            end else if (core_wdata == `FSW_KEY_SECOND && key_reg == K_FIRST) begin
                key_next = K_SECOND;
            end else begin
                key_next = K_NONE;
            end
        end else if (any_strobe) begin
            key_next = K_NONE;
        end else if (slot_done && !strobe_seen_reg) begin
            key_next = K_NONE;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            key_reg <= K_NONE;
            strobe_seen_reg <= 1'b0;
        end else begin
            key_reg <= key_next;
            if (slot_done) begin
                strobe_seen_reg <= 1'b0;
            end else if (any_strobe) begin
                strobe_seen_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // sequence control
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        slot_cnt_next = slot_cnt_reg;
        stall_cnt_next = stall_cnt_reg;
        go_latch = 1'b0;
        go_erase = 1'b0;
        go_prog = 1'b0;
        go_uid = 1'b0;
        capture = 1'b0;
        case (state_reg)
            S_IDLE: begin
                slot_cnt_next = 2'h0;
                if (write_request && unlocked) begin
                    state_next = S_WR_SLOTS;
                end else if (read_request) begin
                    state_next = S_RD_LOAD;
                end
            end
            S_RD_LOAD: begin
                capture = 1'b1;
                state_next = S_RD_SLOTS;
            end
            S_RD_SLOTS: begin
                if (slot_done) begin
                    slot_cnt_next = slot_cnt_reg + 2'h1;
                    if (slot_cnt_reg + 2'h1 == `FSW_FORCED_SLOTS) begin
                        state_next = S_IDLE;
                    end
                end
            end
            S_WR_SLOTS: begin
                if (slot_done) begin
                    slot_cnt_next = slot_cnt_reg + 2'h1;
                    if (slot_cnt_reg + 2'h1 == `FSW_FORCED_SLOTS) begin
                        if (stalls(op_reg)) begin
                            state_next = S_STALL;
                            stall_cnt_next = PROG_CYCLES[15:0] - 16'h1;
                            go_erase = (op_reg == `FSW_OP_ERASE);
                            go_prog = (op_reg == `FSW_OP_PROG);
                            go_uid = (op_reg == `FSW_OP_UID);
                        end else begin
                            state_next = S_IDLE;
                            go_latch = 1'b1;
                        end
                    end
                end
            end
            S_STALL: begin
                if (stall_cnt_reg == 16'h0) begin
                    state_next = S_IDLE;
                end else begin
                    stall_cnt_next = stall_cnt_reg - 16'h1;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_reg <= S_IDLE;
            slot_cnt_reg <= 2'h0;
            stall_cnt_reg <= 16'h0;
            op_reg <= `FSW_OP_LOAD;
            cfg_reg <= 1'b0;
            wword_reg <= {`FSW_WORD_W{1'b0}};
            no_operation_slot_reg <= 1'b0;
            core_stall_reg <= 1'b0;
            read_busy_reg <= 1'b0;
            write_busy_reg <= 1'b0;
            unlock_fail_reg <= 1'b0;
            read_data_low_reg <= 8'h00;
            read_data_high_reg <= 6'h00;
        end else begin
            state_reg <= state_next;
            slot_cnt_reg <= slot_cnt_next;
            stall_cnt_reg <= stall_cnt_next;
            // operation parameters frozen at the request
            if (state_reg == S_IDLE && (read_request || write_request)) begin
                op_reg <= op_select;
                cfg_reg <= config_space_select;
                wword_reg <= write_word;
            end
            // unlocked=0 at the request: refused, no memory change
            unlock_fail_reg <= (state_reg == S_IDLE) && write_request && !unlocked;
            no_operation_slot_reg <= (state_next == S_WR_SLOTS);
            core_stall_reg <= (state_next == S_STALL);
            read_busy_reg <= (state_next == S_RD_LOAD) || (state_next == S_RD_SLOTS);
            write_busy_reg <= (state_next == S_WR_SLOTS) || (state_next == S_STALL);
            if (capture) begin
                read_data_low_reg <= flash_rdata[7:0];
                read_data_high_reg <= flash_rdata[13:8];
            end
        end
    end

    // ------------------------------------------------------------
    // flash array
    // ------------------------------------------------------------
    // config select is taken at the request so a late change is harmless
    fsw_flash_array u_array (
        .clk(clk),
        .rst(rst),
        .addr(flash_addr),
        .cfg_space(state_reg == S_IDLE ? config_space_select : cfg_reg),
        .wdata(wword_reg),
        .latch_we(go_latch),
        .erase_row(go_erase),
        .prog_row(go_prog),
        .prog_uid(go_uid),
        .rdata(flash_rdata)
    );
endmodule

// File: tb_flash_self_write_sequencer.sv
// bench for the flash self-write sequencer with a word-level flash model
// strobes change at the falling edge; slot ends come from the core model
`timescale 1ns/1ns
`include "fsw_defines.vh"
module tb_flash_self_write_sequencer;
    localparam N = 20;
    reg clk = 1'h0, rst = 1'h1, slow = 1'h0, cfg = 1'h0;
    reg [4:0] s = 5'h0;
    reg [7:0] wd = 8'h0;
    reg [13:0] ww = 14'h0;
    reg [1:0] op = 2'h0;
    reg [15:0] rnd = 16'h0f1a;
    wire slot_done, no_operation_slot, stall, rbusy, wbusy, fail;
    wire [7:0] al, ah, dl;
    wire [5:0] dh;
    int n_mismatch = 0, samples_checked = 0, nfail = 0;
    int mem[int], lat[int];
    always #20 clk = ~clk;
    always @(negedge clk) if (fail === 1'h1) nfail++;
    fsw_sequencer #(.PROG_CYCLES(N)) uut (.clk(clk), .rst(rst), .core_wdata(wd),
        .addr_low_we(s[0]), .addr_high_we(s[1]), .key_we(s[2]), .write_word(ww),
        .config_space_select(cfg), .op_select(op), .read_request(s[3]), .write_request(s[4]),
        .slot_done(slot_done), .word_address_low_reg(al), .word_address_high_reg(ah),
        .read_data_low_reg(dl), .read_data_high_reg(dh), .no_operation_slot_reg(no_operation_slot),
        .core_stall_reg(stall), .read_busy_reg(rbusy), .write_busy_reg(wbusy),
        .unlock_fail_reg(fail));
    fsw_core_model core (.clk(clk), .rst(rst), .slow(slow), .core_stall_reg(stall),
        .slot_done(slot_done));
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    function [15:0] lfsr(input [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        samples_checked++;
        if (e !== g) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task st(input [4:0] m, input [7:0] d);
        @(negedge clk);
        s = m;
        wd = d;
        @(negedge clk);
        s = 5'h0;
    endtask
    task adr(input [11:0] a);
        st(5'h01, a[7:0]);
        st(5'h02, {4'h0, a[11:8]});
        chk("address", {4'h0, a}, {ah, al});
    endtask
    // returns the stall cycles seen until the sequencer is quiet again
    task idle(output int c);
        c = 0;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 200 && (wbusy !== 1'h0 || rbusy !== 1'h0); i++) begin
            if (stall === 1'h1) c++;
            @(negedge clk);
        end
    endtask
    task wop(input [1:0] o, input [11:0] a, input good);
        int f, c;
        adr(a);
        f = nfail;
        op = o;
        ww = rnd[13:0];
        rnd = lfsr(rnd);
        cfg = (o == `FSW_OP_UID);
        st(5'h04, good ? 8'h55 : 8'haa);
        st(5'h04, good ? 8'haa : 8'h55);
        st(5'h10, 8'h00);
        idle(c);
        chk("stall", (good && o != `FSW_OP_LOAD) ? N : 0, c);
        chk("refused", good ? 0 : 1, nfail - f);
        if (good && o == `FSW_OP_ERASE) begin
            for (int i = 0; i < 32; i++) mem[(a & 12'hfe0) + i] = `FSW_ERASED_WORD;
        end
        if (good && o == `FSW_OP_LOAD) lat[a[4:0]] = ww;
        if (good && o == `FSW_OP_PROG) foreach (lat[i]) mem[(a & 12'hfe0) + i] = lat[i];
    endtask
    // u=1 reads a user id word, which mirrors the latch of the same low index
    task rd(input [11:0] a, input u);
        int c;
        adr(a);
        cfg = u;
        st(5'h08, 8'h00);
        idle(c);
        chk("word", u ? lat[a[1:0]] : mem[a], {dh, dl});
    endtask
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        int r;
        repeat (5) @(negedge clk);
        rst <= 1'h0;
        chk("reset", 0, {ah, dh, dl, no_operation_slot, stall, rbusy, wbusy, fail});
        chk("reset_addr", 0, al);
        r = rnd[11:0] & 12'hfe0;
        wop(`FSW_OP_ERASE, r, 1'h1);
        rd(r + 31, 1'h0);
        slow = 1'h1;
        for (int k = 0; k < 32; k += 15) wop(`FSW_OP_LOAD, r + k, 1'h1);
        slow = 1'h0;
        wop(`FSW_OP_PROG, r, 1'h1);
        for (int k = 0; k < 32; k += 15) rd(r + k, 1'h0);
        wop(`FSW_OP_ERASE, r, 1'h0);
        rd(r + 15, 1'h0);
        wop(`FSW_OP_UID, 12'h001, 1'h1);
        rd(12'h000, 1'h1);
        report_and_stop;
    end
endmodule
